// >>> logic/smbus_clock_buffer_control.v
// SMBus slave control port for a four-output clock buffer
`timescale 1ns/1ps
`default_nettype none
`include "clkbuf_ctrl_defines.vh"
// Contract
// - Slave only; block write and read
// - Stop after any byte keeps bytes
// - Address 1101 plus strap bits at power-up
// - Write: index, count, data; ack all
// - Read returns count then bytes from index
// - Byte 0 enables at 6,5,3,1, reset 1
// - Enable 0 forces output pair low
// - Byte 1 bits 7:6 show strap mode
// - Byte 1 bit 5 picks mode source
// - Software mode bits idle unless selected
// - Byte 2 slew bits, 1 is fast
// - Byte count register, reset gives 8
module smbus_clock_buffer_control (
    // Clock and reset
    input wire sys_clk,
    input wire rst,
    // SMBus pins, open drain data
    input wire smb_clk,
    input wire smb_data_in,
    output reg smb_data_out_q,
    output reg smb_data_oe_q,
    // Straps, latched after reset release
    input wire [2:0] slave_addr_strap,
    input wire [1:0] loop_bw_strap,
    // Per-output enable pins, active high
    input wire [3:0] out_enable_pin,
    // Output controls
    output reg [3:0] out_run_q,
    output reg [3:0] out_edge_fast_q,
    output reg [1:0] swing_sel_q,
    output reg [1:0] pll_mode_q
);
    localparam ST_IDLE = 3'd0;
    localparam ST_ADDR = 3'd1;
    localparam ST_INDEX = 3'd2;
    localparam ST_COUNT = 3'd3;
    localparam ST_WDATA = 3'd4;
    localparam ST_RDATA = 3'd5;
    localparam ST_SKIP = 3'd6;

    reg [2:0] scl_s_q, sda_s_q;
    reg [4:0] strap_s1_q, strap_s2_q;
    reg [3:0] pin_s1_q, pin_s2_q;
    reg wr_pend_q;
    reg straps_done_q;
    reg [2:0] addr_lo_q;
    reg [1:0] pll_strap_q;
    reg [2:0] state_q;
    reg [3:0] bit_cnt_q;
    reg [7:0] shift_q;
    reg [7:0] index_q;
    reg [7:0] wcount_q;
    reg is_read_q;
    reg first_rd_q;
    reg acking_q;
    reg wr_en_q;
    reg [2:0] wr_idx_q;
    reg [7:0] wr_data_q;
    reg [7:0] tx_q;
    wire [7:0] rd_data;
    wire [63:0] bytes_flat;

    // Two-flop synchronisers; stage 0 is read only by stage 1
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            scl_s_q <= 3'b111;
            sda_s_q <= 3'b111;
        end else begin
            scl_s_q <= {scl_s_q[1:0], smb_clk};
            sda_s_q <= {sda_s_q[1:0], smb_data_in};
        end
    end
    wire scl = scl_s_q[1];
    wire sda = sda_s_q[1];
    wire scl_rise = scl_s_q[1] & ~scl_s_q[2];
    wire scl_fall = ~scl_s_q[1] & scl_s_q[2];
    wire start_cond = scl && scl_s_q[2] && sda_s_q[2] && !sda;
    wire stop_cond = scl && scl_s_q[2] && !sda_s_q[2] && sda;
    wire [7:0] rx_byte = {shift_q[6:0], sda};

    // Strap and enable pins cross in; unreset so they settle during reset
    always @(posedge sys_clk) begin
        strap_s1_q <= {loop_bw_strap, slave_addr_strap};
        strap_s2_q <= strap_s1_q;
        pin_s1_q <= out_enable_pin;
        pin_s2_q <= pin_s1_q;
    end

    // Straps caught once, on the first clock after reset release
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            straps_done_q <= 1'b0;
            addr_lo_q <= 3'h0;
            pll_strap_q <= 2'h0;
        end else if (!straps_done_q) begin
            straps_done_q <= 1'b1;
            addr_lo_q <= strap_s2_q[2:0];
            pll_strap_q <= strap_s2_q[4:3];
        end
    end

    // Byte count value, sent as the first read byte; reads do not stop at it
    wire [4:0] rd_limit = bytes_flat[`REG_BYTE_COUNT*8 +: 5];
    wire addr_match = (shift_q[7:1] == {`ADDR_FIXED_HI, addr_lo_q});
    // Next byte to send: count first, then stored bytes
    wire [7:0] tx_next = first_rd_q ? {3'h0, rd_limit} : rd_data;

    // Protocol engine; sampling on rising, driving on falling edge
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            state_q <= ST_IDLE;
            bit_cnt_q <= 4'h0;
            shift_q <= 8'h00;
            index_q <= 8'h00;
            wcount_q <= 8'h00;
            is_read_q <= 1'b0;
            first_rd_q <= 1'b0;
            acking_q <= 1'b0;
            wr_en_q <= 1'b0;
            wr_idx_q <= 3'h0;
            wr_data_q <= 8'h00;
            wr_pend_q <= 1'b0;
            tx_q <= 8'h00;
            smb_data_out_q <= 1'b1;
            smb_data_oe_q <= 1'b0;
        end else begin
            wr_en_q <= 1'b0;
            if (start_cond) begin
                // Repeated start also lands here
                state_q <= ST_ADDR;
                bit_cnt_q <= 4'h0;
                acking_q <= 1'b0;
                wr_pend_q <= 1'b0;
                smb_data_oe_q <= 1'b0;
            end else if (stop_cond) begin
                state_q <= ST_IDLE;
                acking_q <= 1'b0;
                wr_pend_q <= 1'b0;
                smb_data_oe_q <= 1'b0;
            end else if (state_q != ST_IDLE && state_q != ST_SKIP) begin
                if (scl_rise && !acking_q) begin
                    shift_q <= rx_byte;
                    bit_cnt_q <= bit_cnt_q + 4'h1;
                end
                if (scl_rise && acking_q && state_q == ST_RDATA &&
                        is_read_q && sda) begin
                    // Host NAck ends the read, release the line
                    state_q <= ST_SKIP;
                end
                if (scl_fall && bit_cnt_q == 4'h8 && !acking_q) begin
                    bit_cnt_q <= 4'h0;
                    acking_q <= 1'b1;
                    if (state_q == ST_RDATA && is_read_q) begin
                        // Release for host ack
                        smb_data_oe_q <= 1'b0;
                    end else if (state_q == ST_ADDR && !addr_match) begin
                        // Not ours: leave the line released
                        smb_data_oe_q <= 1'b0;
                    end else begin
                        smb_data_out_q <= 1'b0;
                        smb_data_oe_q <= 1'b1;
                    end
                    case (state_q)
                        ST_ADDR: begin
                            if (!addr_match) begin
                                // Ignore everything up to the next start
                                state_q <= ST_SKIP;
                            end else begin
                                is_read_q <= shift_q[0];
                                first_rd_q <= 1'b1;
                                state_q <= shift_q[0] ? ST_RDATA : ST_INDEX;
                            end
                        end
                        ST_INDEX: begin
                            index_q <= shift_q;
                            state_q <= ST_COUNT;
                        end
                        ST_COUNT: begin
                            wcount_q <= shift_q;
                            state_q <= ST_WDATA;
                        end
                        ST_WDATA: begin
                            if (wcount_q != 8'h00) begin
                                // Held until its ack slot has ended
                                wr_pend_q <= (index_q < 8'h08);
                                wr_idx_q <= index_q[2:0];
                                wr_data_q <= shift_q;
                                index_q <= index_q + 8'h01;
                                wcount_q <= wcount_q - 8'h01;
                            end
                        end
                        default: begin
                        end
                    endcase
                end else if (scl_fall && acking_q) begin
                    acking_q <= 1'b0;
                    smb_data_oe_q <= 1'b0;
                    // Commit once the ack slot is over, before any stop
                    wr_en_q <= wr_pend_q;
                    wr_pend_q <= 1'b0;
                    if (state_q == ST_RDATA && is_read_q) begin
                        // Count byte first, then data from index
                        tx_q <= tx_next;
                        if (first_rd_q) begin
                            first_rd_q <= 1'b0;
                        end else begin
                            index_q <= index_q + 8'h01;
                        end
                        // MSB leaves on this same falling edge
                        smb_data_out_q <= 1'b0;
                        smb_data_oe_q <= ~tx_next[7];
                        bit_cnt_q <= 4'h0;
                    end
                end else if (scl_fall && state_q == ST_RDATA &&
                        is_read_q && !acking_q) begin
                    // Open drain: drive only zeros
                    smb_data_out_q <= 1'b0;
                    smb_data_oe_q <= ~tx_q[3'd7 - bit_cnt_q[2:0]];
                end
            end
        end
    end

    config_bytes u_bytes (
        .sys_clk(sys_clk),
        .rst(rst),
        .wr_en(wr_en_q),
        .wr_idx(wr_idx_q),
        .wr_data(wr_data_q),
        .rd_idx(index_q[2:0]),
        .pll_strap(pll_strap_q),
        .rd_data_q(rd_data),
        .bytes_flat(bytes_flat)
    );

    // Output controls registered from the stored bytes, the enable pins and the strap latch
    wire [7:0] oe_b = bytes_flat[`REG_OUTPUT_ENABLES*8 +: 8];
    wire [7:0] pm_b = bytes_flat[`REG_PLL_MODE_AMP*8 +: 8];
    wire [7:0] sl_b = bytes_flat[`REG_OUTPUT_SLEW*8 +: 8];
    wire [3:0] oe_bits = {oe_b[`BIT_OUT3], oe_b[`BIT_OUT2],
        oe_b[`BIT_OUT1], oe_b[`BIT_OUT0]};
    wire [3:0] sl_bits = {sl_b[`BIT_OUT3], sl_b[`BIT_OUT2],
        sl_b[`BIT_OUT1], sl_b[`BIT_OUT0]};
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            out_run_q <= 4'h0;
            out_edge_fast_q <= 4'hf;
            swing_sel_q <= 2'h2;
            pll_mode_q <= 2'h0;
        end else begin
            out_run_q <= oe_bits & pin_s2_q;
            out_edge_fast_q <= sl_bits;
            swing_sel_q <= pm_b[1:0];
            pll_mode_q <= pm_b[`BIT_PLL_SW_SEL] ? pm_b[4:3] :
                pll_strap_q;
        end
    end
endmodule // smbus_clock_buffer_control
`default_nettype wire

// >>> common/clkbuf_ctrl_defines.vh
// Offsets, field positions, reset values and protocol constants
`ifndef CLKBUF_CTRL_DEFINES_VH
`define CLKBUF_CTRL_DEFINES_VH
`define ADDR_FIXED_HI 4'hd
`define REG_OUTPUT_ENABLES 8'h00
`define REG_PLL_MODE_AMP 8'h01
`define REG_OUTPUT_SLEW 8'h02
`define REG_BYTE_COUNT 8'h07
`define NUM_REGS 8
`define RST_OUTPUT_ENABLES 8'hff
`define RST_PLL_MODE_AMP 8'h06
`define RST_OUTPUT_SLEW 8'hff
`define RST_BYTE_COUNT 8'h08
`define RST_OTHER 8'hff
`define MASK_OUTPUT_ENABLES 8'h6a
`define MASK_PLL_MODE_AMP 8'h3b
`define MASK_OUTPUT_SLEW 8'h6a
`define MASK_BYTE_COUNT 8'h1f
`define BIT_OUT3 6
`define BIT_OUT2 5
`define BIT_OUT1 3
`define BIT_OUT0 1
`define BIT_PLL_SW_SEL 5
`endif

// >>> logic/config_bytes.v
// Configuration byte store with registered read port
`timescale 1ns/1ps
`default_nettype none
`include "clkbuf_ctrl_defines.vh"
module config_bytes (
    // Clock and reset
    input wire sys_clk,
    input wire rst,
    // Write port, applied only on an acked byte
    input wire wr_en,
    input wire [2:0] wr_idx,
    input wire [7:0] wr_data,
    // Read port
    input wire [2:0] rd_idx,
    input wire [1:0] pll_strap,
    output reg [7:0] rd_data_q,
    // Stored bytes
    output wire [63:0] bytes_flat
);
    genvar i;
    // One byte per entry, writable bits masked
    generate
        for (i = 0; i < `NUM_REGS; i = i + 1) begin : g_byte
            localparam [7:0] MASK = (i == 0) ? `MASK_OUTPUT_ENABLES :
                (i == 1) ? `MASK_PLL_MODE_AMP :
                (i == 2) ? `MASK_OUTPUT_SLEW :
                (i == 7) ? `MASK_BYTE_COUNT : 8'h00;
            localparam [7:0] RSTV = (i == 0) ? `RST_OUTPUT_ENABLES :
                (i == 1) ? `RST_PLL_MODE_AMP :
                (i == 2) ? `RST_OUTPUT_SLEW :
                (i == 7) ? `RST_BYTE_COUNT : `RST_OTHER;
            // One register per entry keeps every byte single-driven
            reg [7:0] byte_q;
            always @(posedge sys_clk or posedge rst) begin
                if (rst) begin
                    byte_q <= RSTV;
                end else if (wr_en && wr_idx == i) begin
                    byte_q <= (wr_data & MASK) | (RSTV & ~MASK);
                end
            end
            assign bytes_flat[i*8 +: 8] = byte_q;
        end
    endgenerate
    // Readback; pll mode bits show strap latch
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            rd_data_q <= 8'h00;
        end else if (rd_idx == 3'h1) begin
            rd_data_q <= {pll_strap, bytes_flat[13:8]};
        end else begin
            rd_data_q <= bytes_flat[rd_idx*8 +: 8];
        end
    end
endmodule // config_bytes
`default_nettype wire

// >>> tb/smbus_ctrl_properties.sv
// Port-level properties of the SMBus clock buffer control block
`timescale 1ns/1ps
`default_nettype none
module smbus_ctrl_properties (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // SMBus pins and straps
    input wire logic smb_clk,
    input wire logic smb_data_in,
    input wire logic smb_data_out_q,
    input wire logic smb_data_oe_q,
    input wire logic [2:0] slave_addr_strap,
    input wire logic [1:0] loop_bw_strap,
    input wire logic [3:0] out_enable_pin,
    // Output controls
    input wire logic [3:0] out_run_q,
    input wire logic [3:0] out_edge_fast_q,
    input wire logic [1:0] swing_sel_q,
    input wire logic [1:0] pll_mode_q
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    logic [4:0] idle_q;
    // Cycles since data was last pulled low, saturating
    always @(posedge sys_clk or posedge rst) begin
        if (rst) idle_q <= 5'h1f;
        else if (smb_data_oe_q) idle_q <= 5'h00;
        else if (idle_q != 5'h1f) idle_q <= idle_q + 5'h01;
    end
    AST_OUT_ZERO: assert property (smb_data_oe_q |-> !smb_data_out_q)
        else $error("data driven high");
    // Moving data while the clock is high would fake a start or stop
    AST_OE_CLK_LOW: assert property ($changed(smb_data_oe_q) |->
        !$past(smb_clk) && !$past(smb_clk, 2)) else $error("oe moved");
    AST_OE_STANDS: assert property ($rose(smb_data_oe_q) |->
        smb_data_oe_q [*4]) else $error("ack too short");
    AST_RST_DEFAULTS: assert property ($fell(rst) |->
        out_edge_fast_q == 4'hf && swing_sel_q == 2'h2)
        else $error("bad reset values");
    AST_PLL_STRAP: assert property ($fell(rst) |->
        ##[1:3] pll_mode_q == loop_bw_strap) else $error("mode not strap");
    AST_RUN_DEFAULT: assert property ($fell(rst) |->
        ##[1:3] out_run_q == out_enable_pin) else $error("run default");
    AST_RUN_PIN: assert property ((~out_enable_pin
        & ~$past(out_enable_pin) & ~$past(out_enable_pin, 2)
        & ~$past(out_enable_pin, 3) & out_run_q) == 4'h0)
        else $error("run with pin low");
    AST_CFG_AFTER_ACK: assert property ($changed(swing_sel_q)
        || $changed(out_edge_fast_q) |-> smb_data_oe_q || idle_q < 5'h10)
        else $error("change without ack");
    COV_ACK: cover property ($rose(smb_data_oe_q));
    COV_SWING: cover property ($changed(swing_sel_q));
    COV_SW_MODE: cover property (pll_mode_q != loop_bw_strap);
endmodule // smbus_ctrl_properties
bind smbus_clock_buffer_control smbus_ctrl_properties u_props (
    .sys_clk(sys_clk), .rst(rst), .smb_clk(smb_clk),
    .smb_data_in(smb_data_in), .smb_data_out_q(smb_data_out_q),
    .smb_data_oe_q(smb_data_oe_q), .slave_addr_strap(slave_addr_strap),
    .loop_bw_strap(loop_bw_strap), .out_enable_pin(out_enable_pin),
    .out_run_q(out_run_q), .out_edge_fast_q(out_edge_fast_q),
    .swing_sel_q(swing_sel_q), .pll_mode_q(pll_mode_q));
`default_nettype wire

// >>> tb/smbus_host_model.sv
// Behavioural SMBus host; clock stands high between frames
`timescale 1ns/1ps
`default_nettype none
module smbus_host_model (
    // Clock
    input wire logic sys_clk,
    // Bus lines, pull is an open-drain low
    output logic scl,
    output logic sda_pull,
    input wire logic sda
);
    initial begin
        scl = 1'b1;
        sda_pull = 1'b0;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
    endtask
    // 200 ns bit; data moves mid-low, sampled mid-high
    task automatic bit_io(input logic b, output logic r);
        @(posedge sys_clk) scl <= 1'b0;
        tick(2);
        sda_pull <= !b;
        tick(2);
        scl <= 1'b1;
        tick(2);
        r = sda;
        tick(1);
    endtask
    // Start and repeated start share one shape
    task automatic start_cond();
        logic drop;
        bit_io(1'b1, drop);
        sda_pull <= 1'b1;
        tick(3);
    endtask
    task automatic stop_cond();
        logic drop;
        bit_io(1'b0, drop);
        sda_pull <= 1'b0;
        tick(8);
    endtask
    // MSB first, then the acknowledge slot
    task automatic byte_io(input logic [7:0] d, input logic ack_in,
        output logic [7:0] q, output logic ack);
        for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]);
        bit_io(ack_in, ack);
    endtask
endmodule // smbus_host_model
`default_nettype wire

// >>> tb/smbus_clock_buffer_control_tb.sv
// Self-checking bench for the SMBus clock buffer control block
`timescale 1ns/1ps
`default_nettype none
`include "clkbuf_ctrl_defines.vh"
module smbus_clock_buffer_control_tb;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic [2:0] strap = 3'h5;
    logic [1:0] bw = 2'h2;
    logic [3:0] pin = 4'hf;
    wire logic scl, pull, oe, dout;
    wire logic sda = !(oe || pull);
    wire logic [6:0] adr = {`ADDR_FIXED_HI, strap};
    wire logic [3:0] run, fast;
    wire logic [1:0] swing, mode;
    logic [7:0] regs_m [8];
    integer seed = 42;
    int miscompares = 0;
    int checked = 0;
    int t [6] = '{0, 1, 2, 7, 1, 0};
    logic [7:0] q;
    logic a;
    // 40 MHz system clock
    initial forever #12.5 sys_clk = ~sys_clk;
    smbus_clock_buffer_control dut (.sys_clk(sys_clk), .rst(rst),
        .smb_clk(scl), .smb_data_in(sda), .smb_data_out_q(dout),
        .smb_data_oe_q(oe), .slave_addr_strap(strap), .loop_bw_strap(bw),
        .out_enable_pin(pin), .out_run_q(run), .out_edge_fast_q(fast),
        .swing_sel_q(swing), .pll_mode_q(mode));
    smbus_host_model host (.sys_clk(sys_clk), .scl(scl), .sda_pull(pull),
        .sda(sda));
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("unexpected %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // Power-up contents of the model
    task automatic init_model();
        regs_m = '{`RST_OUTPUT_ENABLES, `RST_PLL_MODE_AMP, `RST_OUTPUT_SLEW,
            `RST_OTHER, `RST_OTHER, `RST_OTHER, `RST_OTHER, `RST_BYTE_COUNT};
    endtask
    function automatic logic [7:0] wmask(input int i);
        case (i)
            0: return `MASK_OUTPUT_ENABLES;
            1: return `MASK_PLL_MODE_AMP;
            2: return `MASK_OUTPUT_SLEW;
            7: return `MASK_BYTE_COUNT;
            default: return 8'h00;
        endcase
    endfunction
    // Byte sent by the host, which the device must ack
    task automatic put(input logic [7:0] d);
        host.byte_io(d, 1'b1, q, a);
        chk({7'h0, a}, 8'h00);
    endtask
    task automatic head(input logic [7:0] idx, input logic [6:0] ad);
        host.start_cond();
        host.byte_io({ad, 1'b0}, 1'b1, q, a);
        chk({7'h0, a}, {7'h0, ad != adr});
        if (ad == adr) put(idx);
    endtask
    // Stop after sent bytes even if the count promised more
    task automatic wr(input int idx, input int cnt, input int sent);
        logic [7:0] d, m;
        head(8'(idx), adr);
        put(8'(cnt));
        for (int k = 0; k < sent; k++) begin
            d = 8'($random(seed));
            put(d);
            m = wmask(idx + k);
            regs_m[idx + k] = (regs_m[idx + k] & ~m) | (d & m);
        end
        host.stop_cond();
    endtask
    task automatic rd(input int idx, input int n);
        logic [7:0] e;
        head(8'(idx), adr);
        host.start_cond();
        put({adr, 1'b1});
        host.byte_io(8'hff, 1'b0, q, a);
        chk(q, regs_m[7]);
        for (int k = 0; k < n; k++) begin
            host.byte_io(8'hff, k == n - 1, q, a);
            e = regs_m[idx + k] | ((idx + k == 1) ? {bw, 6'h0} : 8'h0);
            chk(q, e);
        end
        host.stop_cond();
    endtask
    task automatic outs();
        logic [7:0] e, s, p;
        e = regs_m[0];
        s = regs_m[2];
        p = regs_m[1];
        chk({4'h0, run}, {4'h0, {e[6], e[5], e[3], e[1]} & pin});
        chk({4'h0, fast}, {4'h0, s[6], s[5], s[3], s[1]});
        chk({6'h0, swing}, {6'h0, p[1:0]});
        chk({6'h0, mode}, {6'h0, p[5] ? p[4:3] : bw});
    endtask
    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    // Main sequence: defaults, random block writes, partial and refused
    initial begin
        init_model();
        repeat (10) @(posedge sys_clk);
        rst <= 1'b0;
        repeat (4) @(posedge sys_clk);
        outs();
        rd(0, 8);
        for (int k = 0; k < 6; k++) begin
            pin <= 4'($random(seed));
            wr(t[k], (t[k] > 2) ? 1 : 3 - t[k], (t[k] > 2) ? 1 : 3 - t[k]);
            outs();
            rd(0, 8);
        end
        wr(0, 3, 1);
        outs();
        rd(1, 2);
        wr(4, 2, 2);
        rd(3, 5);
        head(8'h00, adr ^ 7'h01);
        host.stop_cond();
        rd(0, 1);
        // Second reset with other straps: defaults and latch again
        rst <= 1'b1;
        strap <= 3'h2;
        bw <= 2'h1;
        init_model();
        repeat (10) @(posedge sys_clk);
        rst <= 1'b0;
        repeat (4) @(posedge sys_clk);
        outs();
        rd(1, 1);
        report_and_stop();
    end
    // Watchdog well past the expected run length
    initial begin
        #2000000;
        miscompares++;
        report_and_stop();
    end
endmodule // smbus_clock_buffer_control_tb
`default_nettype wire
